//--- hw/led_bank_regs.svh
/*
 * Constants of the LED bank control logic: field positions, reset values
 * and timing counts. Assumes inclusion by the package and the modules.
 */
`ifndef LED_BANK_REGS_SVH
`define LED_BANK_REGS_SVH

// ==========================================================================
// Field positions
`define BOOST_FSEL_BIT 0
`define BOOST_AUTO_BIT 3
`define PWM_EN_BIT 0
`define PWM_BANK_BIT 1
`define LV_SPLIT_LOW_BIT 0
`define LV_SPLIT_HIGH_BIT 1
`define RAMP_SEL_IMM_BIT 1
`define RAMP_SEL_SU_BIT 0

// ==========================================================================
// Reset values
`define HV_MAP_RST 3'h0
`define FB_EN_RST 3'h7
`define BOOST_CTRL_RST 8'h00
`define AUTO_THRESH_RST 8'h00
`define FULL_SCALE_RST 5'h00
`define BRIGHT_RST 11'h000
`define LSB_RST 3'h0
`define PWM_CFG_RST 2'h0
`define LV_SPLIT_RST 2'h0
`define RAMP_RST 8'h00
`define PAT_EN_RST 6'h00
`define RAMP_SEL_RST 2'h0
`define CURRENT_OFF 16'h0000

// ==========================================================================
// Duty meter timing: window of 256 cycles, full duty counts 256
`define DUTY_WIN_LAST 8'hff
`define DUTY_ONE 9'h100
`define DUTY_ZERO 9'h000

`endif

//--- hw/led_bank_pkg.sv
/*
 * Types shared by the LED bank control logic.
 * Assumes the constants header is on the include path.
 */
package led_bank_pkg;
    `include "led_bank_regs.svh"

    // Settings addressed by the write strobe
    typedef enum logic [4:0] {
        SEL_HV_MAP, SEL_FB_EN, SEL_BOOST_CTRL, SEL_AUTO_THRESH,
        SEL_FS_A, SEL_FS_B, SEL_BRIGHT_LSB_A, SEL_BRIGHT_MSB_A,
        SEL_BRIGHT_LSB_B, SEL_BRIGHT_MSB_B, SEL_PWM_CFG, SEL_LV_SPLIT,
        SEL_RAMP_CDE, SEL_RAMP_FGH, SEL_PAT_RF_CDE, SEL_PAT_RF_FGH,
        SEL_PAT_EN, SEL_HV_RAMP_SEL
    } cfg_sel_type;

    typedef enum logic [2:0] {
        BANK_C, BANK_D, BANK_E, BANK_F, BANK_G, BANK_H
    } lv_bank_type;

    typedef enum logic [1:0] {
        RAMP_SEPARATE, RAMP_STARTUP_ONLY, RAMP_IMMEDIATE
    } ramp_src_type;
endpackage

//--- hw/pwm_duty_if.sv
/*
 * Carrier between the control top and its PWM duty meter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pwm_duty_if;
    logic pwm_level;
    logic [8:0] duty;
    modport meter (input pwm_level, output duty);
    modport user (output pwm_level, input duty);
endinterface

//--- hw/pwm_duty_meter.sv
/*
 * Measures PWM duty over a fixed window of clock cycles.
 * Assumes the PWM level is already synchronised to clk_i.
 */
`timescale 1ns/1ps
`include "led_bank_regs.svh"
module pwm_duty_meter
    import led_bank_pkg::*;
(
    input wire logic clk_i,
    input wire logic ce_i,
    input wire logic clear_i,
    pwm_duty_if.meter link
);
    logic [7:0] win_reg;
    logic [8:0] high_reg;
    logic [8:0] duty_reg;
    logic win_end;
    logic [8:0] high_next;

    // ==========================================================================
    // Window bookkeeping
    assign win_end = (win_reg == `DUTY_WIN_LAST);
    assign high_next = high_reg + {8'h00, link.pwm_level};
    assign link.duty = duty_reg;

    // Full duty until the first window ends, so brightness is not dimmed early
    always_ff @(posedge clk_i) begin
        if (clear_i) begin
            win_reg <= 8'h00;
            high_reg <= `DUTY_ZERO;
            duty_reg <= `DUTY_ONE;
        end else if (ce_i) begin
            win_reg <= win_reg + 8'h01;
            high_reg <= win_end ? `DUTY_ZERO : high_next;
            if (win_end) begin
                duty_reg <= high_next;
            end
        end
    end
endmodule

//--- hw/led_bank_control.sv
/*
 * Control logic of a lighting power device: bank mapping, current commands,
 * boost feedback and frequency choice, thermal and enable shutdown.
 * Assumes settings arrive as write strobes on clk_i; pins are asynchronous.
 */
`timescale 1ns/1ps
`include "led_bank_regs.svh"
module led_bank_control
    import led_bank_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic hardware_enable_input_i,
    input wire logic pwm_i,
    input wire logic temp_shutdown_i,
    input wire logic temp_release_i,
    input wire logic [2:0] short_detect_i,
    input wire logic fault_clear_i,
    input wire logic cfg_wr_i,
    input cfg_sel_type cfg_sel_i,
    input wire logic [7:0] cfg_data_i,
    output logic [2:0][15:0] hv_sink_current_o,
    output logic boost_enable_o,
    output logic charge_pump_enable_o,
    output logic [2:0] boost_feedback_o,
    output logic boost_freq_1mhz_o,
    output logic [2:0] short_fault_o,
    output ramp_src_type hv_runtime_ramp_o,
    output lv_bank_type [5:0] lv_sink_bank_o,
    output logic [5:0] lv_sink_enable_o,
    output logic [5:0] lv_pattern_run_o,
    output logic [5:0][7:0] lv_bank_ramp_o
);
    // ==========================================================================
    // Current command: full scale times code times duty, duty one = 256
    function automatic logic [15:0] scale(input logic [4:0] fs, input logic [10:0] code,
                                          input logic [8:0] duty);
        logic [24:0] prod;
        prod = 25'({fs, 11'h000} >> 11) * 25'(code) * 25'(duty);
        scale = prod[23:8];
    endfunction

    // ==========================================================================
    // Pin synchronisers
    logic [6:0] pin_meta_reg;
    logic [6:0] pin_sync_reg;
    logic hardware_enable_input_s;
    logic pwm_s;
    logic hot_s;
    logic warm_s;
    logic [2:0] short_s;

    // Two stages for every asynchronous pin; only stage two is read
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pin_meta_reg <= 7'h00;
            pin_sync_reg <= 7'h00;
        end else if (ce_i) begin
            pin_meta_reg <= {short_detect_i, temp_release_i, temp_shutdown_i, pwm_i,
                             hardware_enable_input_i};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign hardware_enable_input_s = pin_sync_reg[0];
    assign pwm_s = pin_sync_reg[1];
    assign hot_s = pin_sync_reg[2];
    assign warm_s = pin_sync_reg[3];
    assign short_s = pin_sync_reg[6:4];

    // ==========================================================================
    // Settings registers
    logic clear;
    logic [2:0] hv_map_reg;
    logic [2:0] fb_en_reg;
    logic [7:0] boost_ctrl_reg;
    logic [7:0] thresh_reg;
    logic [1:0][4:0] fs_reg;
    logic [1:0][2:0] lsb_hold_reg;
    logic [1:0][10:0] bright_reg;
    logic [1:0] pwm_cfg_reg;
    logic [1:0] lv_split_reg;
    logic [1:0][7:0] lv_ramp_reg;
    logic [1:0][7:0] pat_rf_reg;
    logic [5:0] pat_en_reg;
    logic [1:0] ramp_sel_reg;

    // Enable pin low clears every register but the pin synchronisers, like a reset
    assign clear = !resetn_i || !hardware_enable_input_s;

    // One write strobe per setting; the low brightness part is only held
    always_ff @(posedge clk_i) begin
        if (clear) begin
            hv_map_reg <= `HV_MAP_RST;
            fb_en_reg <= `FB_EN_RST;
            boost_ctrl_reg <= `BOOST_CTRL_RST;
            thresh_reg <= `AUTO_THRESH_RST;
            fs_reg <= {2{`FULL_SCALE_RST}};
            lsb_hold_reg <= {2{`LSB_RST}};
            bright_reg <= {2{`BRIGHT_RST}};
            pwm_cfg_reg <= `PWM_CFG_RST;
            lv_split_reg <= `LV_SPLIT_RST;
            lv_ramp_reg <= {2{`RAMP_RST}};
            pat_rf_reg <= {2{`RAMP_RST}};
            pat_en_reg <= `PAT_EN_RST;
            ramp_sel_reg <= `RAMP_SEL_RST;
        end else if (ce_i && cfg_wr_i) begin
            unique case (cfg_sel_i)
                SEL_HV_MAP: hv_map_reg <= cfg_data_i[2:0];
                SEL_FB_EN: fb_en_reg <= cfg_data_i[2:0];
                SEL_BOOST_CTRL: boost_ctrl_reg <= cfg_data_i;
                SEL_AUTO_THRESH: thresh_reg <= cfg_data_i;
                SEL_FS_A: fs_reg[0] <= cfg_data_i[4:0];
                SEL_FS_B: fs_reg[1] <= cfg_data_i[4:0];
                SEL_BRIGHT_LSB_A: lsb_hold_reg[0] <= cfg_data_i[2:0];
                SEL_BRIGHT_MSB_A: bright_reg[0] <= {cfg_data_i, lsb_hold_reg[0]};
                SEL_BRIGHT_LSB_B: lsb_hold_reg[1] <= cfg_data_i[2:0];
                SEL_BRIGHT_MSB_B: bright_reg[1] <= {cfg_data_i, lsb_hold_reg[1]};
                SEL_PWM_CFG: pwm_cfg_reg <= cfg_data_i[1:0];
                SEL_LV_SPLIT: lv_split_reg <= cfg_data_i[1:0];
                SEL_RAMP_CDE: lv_ramp_reg[0] <= cfg_data_i;
                SEL_RAMP_FGH: lv_ramp_reg[1] <= cfg_data_i;
                SEL_PAT_RF_CDE: pat_rf_reg[0] <= cfg_data_i;
                SEL_PAT_RF_FGH: pat_rf_reg[1] <= cfg_data_i;
                SEL_PAT_EN: pat_en_reg <= cfg_data_i[5:0];
                SEL_HV_RAMP_SEL: ramp_sel_reg <= cfg_data_i[1:0];
            endcase
        end
    end

    // ==========================================================================
    // Thermal shutdown and short faults
    logic hot_reg;
    logic active;
    logic [2:0] fault_reg;
    logic [2:0] fault_next;

    // Set wins over clear so a short seen during the clear is kept
    assign fault_next = (fault_reg & ~{3{fault_clear_i}}) | (short_s & fb_en_reg);
    assign active = hardware_enable_input_s && !hot_reg;

    // Hysteresis: trip on the hot comparator, release only once below warm
    always_ff @(posedge clk_i) begin
        if (clear) begin
            hot_reg <= 1'b0;
            fault_reg <= 3'h0;
        end else if (ce_i) begin
            hot_reg <= hot_s || (hot_reg && warm_s);
            fault_reg <= fault_next;
        end
    end

    // ==========================================================================
    // Bank currents with PWM duty
    pwm_duty_if duty_link();
    logic [1:0][8:0] duty_use;
    logic [1:0][15:0] bank_cur;
    logic [2:0][15:0] cur_reg;

    assign duty_link.pwm_level = pwm_s;

    pwm_duty_meter meter_u (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .clear_i(clear),
        .link(duty_link.meter)
    );

    // Only the bank chosen by the PWM setting sees the measured duty
    assign duty_use[0] = (pwm_cfg_reg[`PWM_EN_BIT] && !pwm_cfg_reg[`PWM_BANK_BIT]) ?
                         duty_link.duty : `DUTY_ONE;
    assign duty_use[1] = (pwm_cfg_reg[`PWM_EN_BIT] && pwm_cfg_reg[`PWM_BANK_BIT]) ?
                         duty_link.duty : `DUTY_ONE;
    assign bank_cur[0] = scale(fs_reg[0], bright_reg[0], duty_use[0]);
    assign bank_cur[1] = scale(fs_reg[1], bright_reg[1], duty_use[1]);

    // Sink currents registered so they never glitch on a mapping change
    always_ff @(posedge clk_i) begin
        if (clear) begin
            cur_reg <= {3{`CURRENT_OFF}};
        end else if (ce_i) begin
            for (int i = 0; i < 3; i++) begin
                cur_reg[i] <= active ? bank_cur[hv_map_reg[i]] : `CURRENT_OFF;
            end
        end
    end

    assign hv_sink_current_o = cur_reg;

    // ==========================================================================
    // Boost and charge pump control
    logic above_thresh;
    logic [7:0] code_msb;

    // Larger of the two banks drives the load, so it decides the frequency
    assign code_msb = (bright_reg[0][10:3] > bright_reg[1][10:3]) ? bright_reg[0][10:3] :
                      bright_reg[1][10:3];
    assign above_thresh = code_msb > thresh_reg;
    assign boost_freq_1mhz_o = boost_ctrl_reg[`BOOST_AUTO_BIT] ? above_thresh :
                               boost_ctrl_reg[`BOOST_FSEL_BIT];
    assign boost_enable_o = active;
    assign charge_pump_enable_o = active;
    assign boost_feedback_o = active ? fb_en_reg : 3'h0;
    assign short_fault_o = fault_reg;

    // Upper bit set forces an immediate change whatever the lower bit
    assign hv_runtime_ramp_o = ramp_sel_reg[`RAMP_SEL_IMM_BIT] ? RAMP_IMMEDIATE :
                               ramp_sel_reg[`RAMP_SEL_SU_BIT] ? RAMP_STARTUP_ONLY :
                               RAMP_SEPARATE;

    // ==========================================================================
    // Low-voltage bank mapping and ramp source
    assign lv_sink_bank_o[0] = BANK_C;
    assign lv_sink_bank_o[1] = lv_split_reg[`LV_SPLIT_LOW_BIT] ? BANK_D : BANK_C;
    assign lv_sink_bank_o[2] = lv_split_reg[`LV_SPLIT_LOW_BIT] ? BANK_E : BANK_C;
    assign lv_sink_bank_o[3] = BANK_F;
    assign lv_sink_bank_o[4] = lv_split_reg[`LV_SPLIT_HIGH_BIT] ? BANK_G : BANK_F;
    assign lv_sink_bank_o[5] = lv_split_reg[`LV_SPLIT_HIGH_BIT] ? BANK_H : BANK_F;
    assign lv_sink_enable_o = active ? 6'h3f : 6'h00;
    assign lv_pattern_run_o = active ? pat_en_reg : 6'h00;

    // Banks 0-2 are C-E and share group 0; 3-5 are F-H and share group 1
    for (genvar k = 0; k < 6; k++) begin : g_lv
        assign lv_bank_ramp_o[k] = pat_en_reg[k] ? pat_rf_reg[k / 3] : lv_ramp_reg[k / 3];
    end
endmodule

//--- tb/pwm_source.sv
/* Stand-in for the host's PWM source on the PWM pin.
   Assumes the bench clock; duty is high cycles per 256. */
`timescale 1ns/1ps
module pwm_source (
    input wire logic clk_i,
    input wire logic [8:0] high_i,
    output logic pwm_o
);
    logic [7:0] phase_reg = 8'h00;
    // ====================
    // Period of 256 cycles
    // Period equal to the meter window keeps the count exact at any phase
    always @(posedge clk_i) begin
        phase_reg <= #1 phase_reg + 8'h01;
    end
    assign pwm_o = {1'b0, phase_reg} < high_i;
endmodule

//--- tb/led_bank_control_properties.sv
/* Port checker of the LED bank control logic.
   Assumes one clock domain; bound to the top module below. */
`timescale 1ns/1ps
module led_bank_control_properties import led_bank_pkg::*; (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic hardware_enable_input_i,
    input wire logic temp_shutdown_i,
    input wire logic temp_release_i,
    input wire logic [2:0] short_detect_i,
    input wire logic cfg_wr_i,
    input cfg_sel_type cfg_sel_i,
    input wire logic [2:0][15:0] hv_sink_current_o,
    input wire logic boost_enable_o,
    input wire logic charge_pump_enable_o,
    input wire logic [2:0] boost_feedback_o,
    input wire logic boost_freq_1mhz_o,
    input wire logic [2:0] short_fault_o,
    input ramp_src_type hv_runtime_ramp_o,
    input lv_bank_type [5:0] lv_sink_bank_o,
    input wire logic [5:0] lv_sink_enable_o
);
    // Qualified pin states; frozen clock would hold the synchronisers
    wire hardware_enable_input_off = ce_i && !hardware_enable_input_i;
    wire hot_now = ce_i && temp_shutdown_i;
    wire cool_now = ce_i && hardware_enable_input_i && !temp_shutdown_i && !temp_release_i;
    wire [17:0] lv_default = {BANK_F, BANK_F, BANK_F, BANK_C, BANK_C, BANK_C};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // ====================
    // Shutdown and enable
    a_outputs_follow_boost: assert property (
        charge_pump_enable_o == boost_enable_o && lv_sink_enable_o == {6{boost_enable_o}})
        else $error("pump or sinks differ from boost");
    a_feedback_when_off: assert property (!boost_enable_o |-> boost_feedback_o == 3'h0)
        else $error("feedback on while shut down");
    a_hot_shutdown: assert property (hot_now [*4] |=> !boost_enable_o)
        else $error("boost on while hot");
    a_cool_restart: assert property (cool_now [*5] |=> boost_enable_o)
        else $error("boost off while cool");
    a_hardware_enable_input_shutdown: assert property (hardware_enable_input_off [*3] |=> !boost_enable_o)
        else $error("boost on with enable low");
    a_hardware_enable_input_defaults: assert property (hardware_enable_input_off [*4] |=> hv_sink_current_o == '0 &&
        short_fault_o == 3'h0 && lv_sink_bank_o == lv_default && hv_runtime_ramp_o == RAMP_SEPARATE)
        else $error("defaults not restored");
    // ====================
    // Faults, frequency, brightness
    a_fault_has_cause: assert property (
        (short_fault_o & ~$past(short_fault_o) & ~($past(short_detect_i, 3) | $past(short_detect_i, 4))) == 3'h0)
        else $error("fault raised without short");
    a_freq_by_write: assert property (
        $changed(boost_freq_1mhz_o) |-> $past(cfg_wr_i) || !$past(boost_enable_o))
        else $error("frequency changed without write");
    a_lsb_holds_current: assert property (
        cfg_wr_i && cfg_sel_i == SEL_BRIGHT_LSB_A ##1 !cfg_wr_i |=> hv_sink_current_o == $past(hv_sink_current_o, 2))
        else $error("current moved on low part write");
endmodule
bind led_bank_control led_bank_control_properties led_bank_control_properties_inst (
    .clk_i, .resetn_i, .ce_i, .hardware_enable_input_i, .temp_shutdown_i, .temp_release_i,
    .short_detect_i, .cfg_wr_i, .cfg_sel_i, .hv_sink_current_o, .boost_enable_o, .charge_pump_enable_o,
    .boost_feedback_o, .boost_freq_1mhz_o, .short_fault_o, .hv_runtime_ramp_o, .lv_sink_bank_o,
    .lv_sink_enable_o);

//--- tb/led_bank_control_bench.sv
/* Self-checking bench of the LED bank control logic.
   Assumes the checker binds itself; PWM comes from pwm_source. */
`timescale 1ns/1ps
module led_bank_control_bench import led_bank_pkg::*;;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce = 1'b1;
    logic hardware_enable_input = 1'b1;
    logic hot = 1'b0;
    logic warm = 1'b0;
    logic fclr = 1'b0;
    logic wr_en = 1'b0;
    logic pwm, boost, pump, freq;
    logic [2:0] short = 3'h0;
    logic [2:0] fb, fault;
    logic [7:0] data = 8'h00;
    logic [8:0] high = 9'h040;
    cfg_sel_type sel = SEL_HV_MAP;
    logic [2:0][15:0] cur;
    ramp_src_type rsel;
    lv_bank_type [5:0] banks;
    logic [5:0] lv_en, pat;
    logic [5:0][7:0] ramp;
    int errors = 0;
    int checks = 0;
    localparam logic [17:0] lv_default = {BANK_F, BANK_F, BANK_F, BANK_C, BANK_C, BANK_C};

    always #5 clk_i = ~clk_i;

    led_bank_control led_bank_control_inst (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
        .hardware_enable_input_i(hardware_enable_input), .pwm_i(pwm), .temp_shutdown_i(hot), .temp_release_i(warm),
        .short_detect_i(short), .fault_clear_i(fclr), .cfg_wr_i(wr_en), .cfg_sel_i(sel), .cfg_data_i(data),
        .hv_sink_current_o(cur), .boost_enable_o(boost), .charge_pump_enable_o(pump), .boost_feedback_o(fb),
        .boost_freq_1mhz_o(freq), .short_fault_o(fault), .hv_runtime_ramp_o(rsel), .lv_sink_bank_o(banks),
        .lv_sink_enable_o(lv_en), .lv_pattern_run_o(pat), .lv_bank_ramp_o(ramp));
    pwm_source pwm_source_inst (.clk_i(clk_i), .high_i(high), .pwm_o(pwm));

    // ====================
    // Access tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // One write strobe; always a gap cycle before the next
    task automatic wr(input cfg_sel_type s, input logic [7:0] d);
        cyc(1);
        wr_en = 1'b1;
        sel = s;
        data = d;
        cyc(1);
        wr_en = 1'b0;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fq(input logic [7:0] ctrl, input logic [7:0] thr, input logic exp);
        wr(SEL_AUTO_THRESH, thr);
        wr(SEL_BOOST_CTRL, ctrl);
        chk(freq, exp);
    endtask
    task automatic end_sim();
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ====================
    // Watchdog, far beyond the roughly 710 cycles needed
    initial begin
        #200000;
        errors++;
        end_sim();
    end

    // ====================
    // Test sequence
    initial begin
        cyc(2);
        resetn_i = 1'b1;
        cyc(4);
        chk({fb, freq, banks}, {3'h7, 1'b0, lv_default});
        wr(SEL_FS_A, 8'h10);
        wr(SEL_BRIGHT_LSB_A, 8'h05);
        cyc(3);
        chk(cur, 48'h0);
        wr(SEL_BRIGHT_MSB_A, 8'h80);
        cyc(2);
        chk(cur, {3{16'h4050}});
        wr(SEL_HV_MAP, 8'h02);
        wr(SEL_FS_B, 8'h02);
        wr(SEL_BRIGHT_MSB_B, 8'h01);
        cyc(2);
        chk(cur, {16'h4050, 16'h0010, 16'h4050});
        fq(8'h01, 8'h00, 1'b1);
        fq(8'h00, 8'h7f, 1'b0);
        fq(8'h09, 8'h80, 1'b0);
        fq(8'h08, 8'h7f, 1'b1);
        wr(SEL_FB_EN, 8'h05);
        chk(fb, 3'h5);
        short = 3'h7;
        cyc(5);
        chk(fault, 3'h5);
        // Clear while the short persists: the set must win
        fclr = 1'b1;
        cyc(1);
        fclr = 1'b0;
        chk(fault, 3'h5);
        short = 3'h0;
        cyc(4);
        fclr = 1'b1;
        cyc(1);
        fclr = 1'b0;
        chk(fault, 3'h0);
        wr(SEL_LV_SPLIT, 8'h01);
        chk(banks, {BANK_F, BANK_F, BANK_F, BANK_E, BANK_D, BANK_C});
        wr(SEL_LV_SPLIT, 8'h03);
        chk(banks, {BANK_H, BANK_G, BANK_F, BANK_E, BANK_D, BANK_C});
        wr(SEL_RAMP_CDE, 8'h12);
        wr(SEL_RAMP_FGH, 8'h34);
        wr(SEL_PAT_RF_FGH, 8'h56);
        wr(SEL_PAT_EN, 8'h20);
        chk(ramp, {8'h56, 8'h34, 8'h34, 8'h12, 8'h12, 8'h12});
        chk(pat, 6'h20);
        wr(SEL_PAT_RF_CDE, 8'h78);
        wr(SEL_PAT_EN, 8'h21);
        chk(ramp, {8'h56, 8'h34, 8'h34, 8'h12, 8'h12, 8'h78});
        chk(pat, 6'h21);
        // Codes 2 and 3 both mean immediate
        for (int i = 0; i < 4; i++) begin
            wr(SEL_HV_RAMP_SEL, 8'(i));
            chk(rsel, i > 1 ? RAMP_IMMEDIATE : ramp_src_type'(i));
        end
        wr(SEL_PWM_CFG, 8'h01);
        cyc(600);
        chk(cur, {16'h1014, 16'h0010, 16'h1014});
        wr(SEL_PWM_CFG, 8'h03);
        cyc(2);
        chk(cur, {16'h4050, 16'h0004, 16'h4050});
        // Clock enable low: a write must not land
        ce = 1'b0;
        wr(SEL_BOOST_CTRL, 8'h00);
        ce = 1'b1;
        chk(freq, 1'b1);
        hot = 1'b1;
        warm = 1'b1;
        cyc(5);
        chk({boost, pump, lv_en}, 8'h00);
        hot = 1'b0;
        cyc(5);
        chk(boost, 1'b0);
        warm = 1'b0;
        cyc(5);
        chk({boost, pump, lv_en}, 8'hff);
        hardware_enable_input = 1'b0;
        cyc(5);
        chk({cur, boost}, 49'h0);
        hardware_enable_input = 1'b1;
        cyc(4);
        chk({fb, freq, banks}, {3'h7, 1'b0, lv_default});
        end_sim();
    end
endmodule
